/* File: logic/csf_alu.sv */
// combinational alu producing result and flag updates
`timescale 1ns/100ps
module csf_alu (
    // operation side
    csf_alu_if.alu x
);
    import csf_pkg::*;
    wire is_add = (x.op == CSF_OP_ADD) || (x.op == CSF_OP_ADC);
    wire is_sub = (x.op == CSF_OP_SUB) || (x.op == CSF_OP_SBC);
    wire c_used = ((x.op == CSF_OP_ADC) || (x.op == CSF_OP_SBC)) && x.cin;
    wire [8:0] sum9 = {1'b0, x.a} + {1'b0, x.b} + {8'h00, c_used};
    wire [8:0] dif9 = {1'b0, x.a} - {1'b0, x.b} - {8'h00, c_used};
    wire [4:0] hsum = {1'b0, x.a[3:0]} + {1'b0, x.b[3:0]} + {4'h0, c_used};
    wire [4:0] hdif = {1'b0, x.a[3:0]} - {1'b0, x.b[3:0]} - {4'h0, c_used};
    // decimal fixup from carry, half and direction bits
    wire fix_lo = x.half_in || (!x.dec_in && (x.a[3:0] > CSF_BCD_LIMIT));
    wire fix_hi = x.cin || (!x.dec_in && (x.a > CSF_HI_LIMIT));
    wire [7:0] adj = (fix_lo ? CSF_ADJ_LO : 8'h00) | (fix_hi ? CSF_ADJ_HI : 8'h00);
    wire [7:0] da_res = x.dec_in ? x.a - adj : x.a + adj;
    logic [7:0] r;
    logic c;
    logic v;
    logic [7:0] m;
    always_comb begin
        r = x.a;
        c = x.cin;
        v = 1'b0;
        m = 8'h00;
        case (x.op)
            CSF_OP_ADD, CSF_OP_ADC: begin
                r = sum9[7:0];
                c = sum9[8];
                v = (x.a[7] == x.b[7]) && (r[7] != x.a[7]);
                m = 8'hfc;
            end
            CSF_OP_SUB, CSF_OP_SBC: begin
                r = dif9[7:0];
                c = dif9[8];
                v = (x.a[7] != x.b[7]) && (r[7] != x.a[7]);
                m = 8'hfc;
            end
            CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR: begin
                r = (x.op == CSF_OP_AND) ? (x.a & x.b) :
                    (x.op == CSF_OP_OR) ? (x.a | x.b) : (x.a ^ x.b);
                v = 1'b0;
                m = 8'h70;
            end
            CSF_OP_RL, CSF_OP_RLC: begin
                r = {x.a[6:0], (x.op == CSF_OP_RLC) ? x.cin : x.a[7]};
                c = x.a[7];
                v = r[7] ^ x.a[7];
                m = 8'hf0;
            end
            CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA: begin
                r = {(x.op == CSF_OP_RRC) ? x.cin : (x.op == CSF_OP_SRA) ? x.a[7] : x.a[0],
                     x.a[7:1]};
                c = x.a[0];
                v = r[7] ^ x.a[7];
                m = 8'hf0;
            end
            CSF_OP_BITTEST: begin
                r = x.a & x.b;
                m = 8'h70;
            end
            CSF_OP_SCF, CSF_OP_RCF, CSF_OP_CCF: begin
                c = (x.op == CSF_OP_SCF) ? 1'b1 : (x.op == CSF_OP_RCF) ? 1'b0 : !x.cin;
                m = 8'h80;
            end
            CSF_OP_DECFIX: begin
                r = da_res;
                c = fix_hi;
                m = 8'he0;
            end
            default: begin
                r = x.a;
            end
        endcase
    end
    assign x.res = r;
    assign x.flg_mask = m;
    assign x.flg = {c, (r == 8'h00), r[7], v, is_sub,
                    is_add ? hsum[4] : hdif[4], 2'b00};
endmodule

/* File: logic/csf_alu_if.sv */
// operand and result bundle between flag core and its alu
`timescale 1ns/100ps
interface csf_alu_if;
    import csf_pkg::*;
    csf_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic dec_in;
    logic half_in;
    logic [7:0] res;
    logic [7:0] flg;
    logic [7:0] flg_mask;
    modport core (output op, a, b, cin, dec_in, half_in, input res, flg, flg_mask);
    modport alu (input op, a, b, cin, dec_in, half_in, output res, flg, flg_mask);
endinterface

/* File: logic/csf_flags.sv */
// cpu status flags register with alu, condition test and interrupt bit
`timescale 1ns/100ps
module csf_flags (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // alu operation
    input wire logic op_valid,
    input wire csf_pkg::csf_op_t op_code,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    output logic [7:0] op_result,
    // register file access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // condition evaluation
    input wire csf_pkg::csf_cc_t cond_code,
    output logic cond_true,
    // interrupt sequencer
    input wire logic fast_irq_enter,
    input wire logic interrupt_return_op,
    output logic fast_irq_active_bit,
    output logic irq_block,
    output logic fast_return_sel,
    // register bank
    output logic bank_sel
);
    import csf_pkg::*;

    // ****************************************
    // condition decode
    // ****************************************
    // decimal and half bits are left out of the test on purpose
    function automatic logic csf_cond(input csf_cc_t cc, input logic [7:0] f);
        logic c;
        logic z;
        logic s;
        logic v;
        logic t;
        c = f[CSF_BIT_CARRY];
        z = f[CSF_BIT_ZERO];
        s = f[CSF_BIT_SIGN];
        v = f[CSF_BIT_OVFL];
        case (cc)
            CSF_CC_NEVER: t = 1'b0;
            CSF_CC_ALWAYS: t = 1'b1;
            CSF_CC_LT: t = s ^ v;
            CSF_CC_GE: t = !(s ^ v);
            CSF_CC_LE: t = z || (s ^ v);
            CSF_CC_GT: t = !(z || (s ^ v));
            CSF_CC_ULE: t = c || z;
            CSF_CC_UGT: t = !(c || z);
            CSF_CC_OV: t = v;
            CSF_CC_NOV: t = !v;
            CSF_CC_MI: t = s;
            CSF_CC_PL: t = !s;
            CSF_CC_EQ: t = z;
            CSF_CC_NE: t = !z;
            CSF_CC_ULT: t = c;
            CSF_CC_UGE: t = !c;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // ****************************************
    // alu
    // ****************************************
    csf_alu_if ai();
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] result_reg;
    logic [7:0] rdata_reg;
    logic cond_reg;
    logic fast_reg;
    logic fast_next;
    logic bank_reg;
    logic bank_next;

    assign ai.op = op_valid ? op_code : CSF_OP_NONE;
    assign ai.a = op_a;
    assign ai.b = op_b;
    assign ai.cin = flags_reg[CSF_BIT_CARRY];
    assign ai.dec_in = flags_reg[CSF_BIT_DEC];
    assign ai.half_in = flags_reg[CSF_BIT_HALF];

    csf_alu u_alu (
        .x(ai)
    );

    // ****************************************
    // next state
    // ****************************************
    wire sel_hit = (reg_addr == CSF_FLAGS_ADDR);
    wire wr_hit = reg_wr && sel_hit;
    wire [7:0] wr_mask = 8'hfc;
    // direct write of upper flags; flag update wins over a colliding write
    wire [7:0] wr_val = (flags_reg & ~wr_mask) | (reg_wdata & wr_mask);
    wire [7:0] base = wr_hit ? wr_val : flags_reg;
    wire [7:0] alu_upd = (base & ~ai.flg_mask) | (ai.flg & ai.flg_mask);
    wire sel0 = op_valid && (op_code == CSF_OP_SEL0);
    wire sel1 = op_valid && (op_code == CSF_OP_SEL1);

    assign flags_next = alu_upd;
    // entry takes priority over a return in the same cycle
    assign fast_next = fast_irq_enter ? 1'b1 :
                       interrupt_return_op ? 1'b0 : fast_reg;
    assign bank_next = sel1 ? 1'b1 : sel0 ? 1'b0 :
                       wr_hit ? reg_wdata[CSF_BIT_BANK] : bank_reg;
    wire [7:0] full_flags = {flags_reg[7:2], fast_reg, bank_reg};

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags_reg <= CSF_RESET_VAL;
            fast_reg <= 1'b0;
            bank_reg <= 1'b0;
            result_reg <= 8'h00;
            rdata_reg <= 8'h00;
            cond_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            fast_reg <= fast_next;
            bank_reg <= bank_next;
            result_reg <= ai.res;
            rdata_reg <= (reg_rd && sel_hit) ? full_flags : 8'h00;
            cond_reg <= csf_cond(cond_code, full_flags);
        end
    end

    assign op_result = result_reg;
    assign reg_rdata = rdata_reg;
    assign cond_true = cond_reg;
    assign fast_irq_active_bit = fast_reg;
    assign irq_block = fast_reg;
    assign fast_return_sel = fast_reg;
    assign bank_sel = bank_reg;

    // ****************************************
    // checks
    // ****************************************
    a_fast_set: assert property (@(posedge clk) disable iff (!rstn)
        fast_irq_enter |=> fast_irq_active_bit && irq_block)
        else $error("fast bit not set after entry");
    a_fast_clear: assert property (@(posedge clk) disable iff (!rstn)
        interrupt_return_op && !fast_irq_enter |=> !fast_irq_active_bit)
        else $error("fast bit not cleared by return");
    a_fast_wr_ignored: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit && !fast_irq_enter && !interrupt_return_op |=> $stable(fast_irq_active_bit))
        else $error("direct write changed fast bit");
    a_bank_ops: assert property (@(posedge clk) disable iff (!rstn)
        sel1 |=> bank_sel)
        else $error("bank not set by group one op");
    a_bank_zero: assert property (@(posedge clk) disable iff (!rstn)
        sel0 |=> !bank_sel)
        else $error("bank not cleared by group zero op");
    a_add_carry: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_ADD |=>
        flags_reg[CSF_BIT_CARRY] == (({1'b0, $past(op_a)} + {1'b0, $past(op_b)}) > 9'h0ff))
        else $error("carry wrong after add");
    a_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_ADD, CSF_OP_AND, CSF_OP_RL} |=>
        flags_reg[CSF_BIT_ZERO] == (op_result == 8'h00))
        else $error("zero flag mismatches result");
    a_sign_flag: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_SUB, CSF_OP_OR, CSF_OP_RR} |=>
        flags_reg[CSF_BIT_SIGN] == op_result[7])
        else $error("sign flag mismatches result");
    a_logic_ovfl: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR} |=> !flags_reg[CSF_BIT_OVFL])
        else $error("overflow not cleared by logic op");
    a_dec_dir: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_SUB, CSF_OP_SBC} |=> flags_reg[CSF_BIT_DEC])
        else $error("decimal bit not set by subtract");
    a_shift_carry: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_RL |=> flags_reg[CSF_BIT_CARRY] == $past(op_a[7]))
        else $error("carry not last bit shifted out");
    a_ccf_invert: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_CCF |=> flags_reg[CSF_BIT_CARRY] != $past(flags_reg[7]))
        else $error("carry not inverted");
    c_fast_cycle: cover property (@(posedge clk) disable iff (!rstn)
        fast_irq_enter ##[1:8] interrupt_return_op);
    c_add_overflow: cover property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_ADD ##1 flags_reg[CSF_BIT_OVFL]);
    c_direct_write: cover property (@(posedge clk) disable iff (!rstn) wr_hit);
    c_decfix: cover property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_DECFIX);
    c_bank_switch: cover property (@(posedge clk) disable iff (!rstn)
        sel1 ##1 sel0);

    // ****************************************
    // arithmetic flag checks
    // ****************************************
    // expectations rebuilt from past operands, flags and op_result, not from the alu wires
    a_half_add: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_ADD |=>
        flags_reg[CSF_BIT_HALF] == (({1'b0, $past(op_a[3:0])} + {1'b0, $past(op_b[3:0])}) > 5'h0f))
        else $error("half carry wrong after add");

    a_half_sub: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_SUB |=>
        flags_reg[CSF_BIT_HALF] == ($past(op_b[3:0]) > $past(op_a[3:0])))
        else $error("half borrow wrong after subtract");

    a_sub_borrow: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_SUB |=>
        flags_reg[CSF_BIT_CARRY] == ($past(op_b) > $past(op_a)))
        else $error("borrow wrong after subtract");

    a_adc_carry: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_ADC |=> flags_reg[CSF_BIT_CARRY] ==
        (({1'b0, $past(op_a)} + {1'b0, $past(op_b)} + {8'h00, $past(flags_reg[CSF_BIT_CARRY])}) > 9'h0ff))
        else $error("carry wrong after add with carry");

    a_add_dec: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_ADD, CSF_OP_ADC} |=> !flags_reg[CSF_BIT_DEC])
        else $error("decimal bit not cleared by add");

    a_add_ovfl: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_ADD |=> flags_reg[CSF_BIT_OVFL] ==
        (($past(op_a[7]) == $past(op_b[7])) && (op_result[7] != $past(op_a[7]))))
        else $error("overflow wrong after add");

    a_xor_zero: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_XOR |=>
        flags_reg[CSF_BIT_ZERO] == ($past(op_a) == $past(op_b)))
        else $error("zero flag wrong after xor");

    a_test_zero: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_BITTEST |=>
        flags_reg[CSF_BIT_ZERO] == (($past(op_a) & $past(op_b)) == 8'h00))
        else $error("zero flag wrong after bit test");

    a_shift_sign: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_RL, CSF_OP_RLC, CSF_OP_RRC, CSF_OP_SRA} |=>
        flags_reg[CSF_BIT_SIGN] == op_result[7])
        else $error("sign flag wrong after shift");

    a_rr_carry: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA} |=>
        flags_reg[CSF_BIT_CARRY] == $past(op_a[0]))
        else $error("carry not last bit shifted right");

    // ****************************************
    // carry instruction checks
    // ****************************************
    a_scf_set: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_SCF |=> flags_reg[CSF_BIT_CARRY])
        else $error("carry not set");

    a_rcf_clear: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code == CSF_OP_RCF |=> !flags_reg[CSF_BIT_CARRY])
        else $error("carry not cleared");

    a_carry_only: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op_code inside {CSF_OP_SCF, CSF_OP_RCF, CSF_OP_CCF} && !reg_wr |=>
        $stable(flags_reg[6:2]))
        else $error("carry op touched other flags");

    // ****************************************
    // register access checks
    // ****************************************
    a_rd_data: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && sel_hit |=> reg_rdata == $past(full_flags))
        else $error("read data not the flags");

    a_rd_miss: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && !sel_hit |=> reg_rdata == 8'h00)
        else $error("read of other address returned data");

    a_wr_upper: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit && !op_valid |=> flags_reg[7:2] == $past(reg_wdata[7:2]))
        else $error("direct write did not land");

    a_bank_write: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit && !op_valid |=> bank_sel == $past(reg_wdata[CSF_BIT_BANK]))
        else $error("direct write did not set bank bit");

    a_wr_miss: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && !sel_hit && !op_valid |=> $stable(flags_reg))
        else $error("write to other address changed flags");

    a_idle_hold: assert property (@(posedge clk) disable iff (!rstn)
        !op_valid && !reg_wr |=> $stable(flags_reg))
        else $error("flags changed without op or write");

    // ****************************************
    // condition, reset and fast bit checks
    // ****************************************
    a_cond_eq: assert property (@(posedge clk) disable iff (!rstn)
        cond_code == CSF_CC_EQ |=> cond_true == $past(flags_reg[CSF_BIT_ZERO]))
        else $error("equal condition wrong");

    a_cond_mi: assert property (@(posedge clk) disable iff (!rstn)
        cond_code == CSF_CC_MI |=> cond_true == $past(flags_reg[CSF_BIT_SIGN]))
        else $error("minus condition wrong");

    a_cond_ult: assert property (@(posedge clk) disable iff (!rstn)
        cond_code == CSF_CC_ULT |=> cond_true == $past(flags_reg[CSF_BIT_CARRY]))
        else $error("carry condition wrong");

    a_cond_ov: assert property (@(posedge clk) disable iff (!rstn)
        cond_code == CSF_CC_OV |=> cond_true == $past(flags_reg[CSF_BIT_OVFL]))
        else $error("overflow condition wrong");

    // reset check must run while reset is low, so no disable here
    a_reset_clear: assert property (@(posedge clk)
        !rstn |=> !fast_irq_active_bit && !bank_sel)
        else $error("reset left fast or bank bit set");

    a_block_follow: assert property (@(posedge clk) disable iff (!rstn)
        fast_irq_active_bit |-> irq_block && fast_return_sel)
        else $error("fast bit set without block");
endmodule

/* File: logic/csf_pkg.sv */
// constants and types for the cpu status flags block
package csf_pkg;
    localparam logic [7:0] CSF_FLAGS_ADDR = 8'hd5;
    localparam int CSF_W = 8;
    localparam int CSF_BIT_CARRY = 7;
    localparam int CSF_BIT_ZERO = 6;
    localparam int CSF_BIT_SIGN = 5;
    localparam int CSF_BIT_OVFL = 4;
    localparam int CSF_BIT_DEC = 3;
    localparam int CSF_BIT_HALF = 2;
    localparam int CSF_BIT_FAST = 1;
    localparam int CSF_BIT_BANK = 0;
    localparam logic [7:0] CSF_RESET_VAL = 8'h00;
    localparam logic [3:0] CSF_BCD_LIMIT = 4'h9;
    localparam logic [7:0] CSF_ADJ_LO = 8'h06;
    localparam logic [7:0] CSF_ADJ_HI = 8'h60;
    localparam logic [7:0] CSF_HI_LIMIT = 8'h99;
    // alu operation classes
    typedef enum logic [4:0] {
        CSF_OP_NONE, CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC,
        CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_RL, CSF_OP_RLC,
        CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA, CSF_OP_BITTEST, CSF_OP_SCF,
        CSF_OP_RCF, CSF_OP_CCF, CSF_OP_DECFIX, CSF_OP_SEL0, CSF_OP_SEL1
    } csf_op_t;
    // condition codes for jumps; only flag bits 7..4 are testable
    typedef enum logic [3:0] {
        CSF_CC_NEVER, CSF_CC_LT, CSF_CC_LE, CSF_CC_ULE, CSF_CC_OV,
        CSF_CC_MI, CSF_CC_EQ, CSF_CC_ULT, CSF_CC_ALWAYS, CSF_CC_GE,
        CSF_CC_GT, CSF_CC_UGT, CSF_CC_NOV, CSF_CC_PL, CSF_CC_NE, CSF_CC_UGE
    } csf_cc_t;
endpackage

/* File: verification/csf_seq_model.sv */
// behavioural interrupt sequencer facing the flags block
`timescale 1ns/100ps
module csf_seq_model (
    // clock and reset
    clk,
    rstn,
    // commands from the bench
    want_fast,
    want_ret,
    // block side
    irq_block,
    fast_irq_enter,
    interrupt_return_op
);
    input wire logic clk;
    input wire logic rstn;
    input wire logic want_fast;
    input wire logic want_ret;
    input wire logic irq_block;
    output logic fast_irq_enter;
    output logic interrupt_return_op;
    // one-cycle pulses; no new entry while blocked, as the real sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fast_irq_enter <= 1'b0;
            interrupt_return_op <= 1'b0;
        end else begin
            fast_irq_enter <= want_fast && !irq_block && !fast_irq_enter;
            interrupt_return_op <= want_ret && !interrupt_return_op;
        end
    end
endmodule

/* File: verification/tb_cpu_status_flags.sv */
// self-checking bench for the cpu status flags block
`timescale 1ns/100ps
module tb_cpu_status_flags;
    import csf_pkg::*;
    // ****************
    // signals
    // ****************
    logic clk, rstn, op_valid, reg_wr, reg_rd, cond_true, want_fast, want_ret;
    logic fast_irq_enter, interrupt_return_op, fast_bit, irq_block, fast_ret, bank_sel;
    logic [7:0] op_a, op_b, op_result, reg_addr, reg_wdata, reg_rdata;
    csf_op_t op_code;
    csf_cc_t cond_code;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    csf_flags dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
        .op_a(op_a), .op_b(op_b), .op_result(op_result), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cond_code(cond_code), .cond_true(cond_true), .fast_irq_enter(fast_irq_enter),
        .interrupt_return_op(interrupt_return_op), .fast_irq_active_bit(fast_bit),
        .irq_block(irq_block), .fast_return_sel(fast_ret), .bank_sel(bank_sel));
    csf_seq_model seq (.clk(clk), .rstn(rstn), .want_fast(want_fast), .want_ret(want_ret),
        .irq_block(irq_block), .fast_irq_enter(fast_irq_enter),
        .interrupt_return_op(interrupt_return_op));
    // ****************
    // helpers
    // ****************
    task automatic complete_run;
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        reg_wr = 1'b1; // never beside op_valid
        reg_addr = adr;
        reg_wdata = d;
        step;
        reg_wr = 1'b0;
    endtask
    // op, then result check if asked, then masked flags read back
    task automatic op_chk(input csf_op_t c, input logic [7:0] a, input logic [7:0] b,
        input logic cr, input logic [7:0] res, input logic [7:0] m, input logic [7:0] e);
        op_valid = 1'b1;
        op_code = c;
        op_a = a;
        op_b = b;
        step;
        op_valid = 1'b0;
        if (cr) chk(op_result, res);
        reg_rd = 1'b1;
        reg_addr = CSF_FLAGS_ADDR;
        step;
        reg_rd = 1'b0;
        chk(reg_rdata & m, e);
    endtask
    task automatic cond_scan(input logic [7:0] f, output logic [15:0] v);
        wr(CSF_FLAGS_ADDR, f);
        for (int i = 0; i < 16; i++) begin
            cond_code = csf_cc_t'(i);
            step;
            v[i] = cond_true;
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_arith;
        op_chk(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 8'hff, 8'h00);
        op_chk(CSF_OP_ADD, 8'hff, 8'h01, 1'b1, 8'h00, 8'hff, 8'hc4);
        op_chk(CSF_OP_SUB, 8'h00, 8'h01, 1'b1, 8'hff, 8'hff, 8'hac);
        op_chk(CSF_OP_ADD, 8'h7f, 8'h01, 1'b1, 8'h80, 8'hff, 8'h34);
        op_chk(CSF_OP_AND, 8'hff, 8'h00, 1'b1, 8'h00, 8'hff, 8'h44);
        op_chk(CSF_OP_OR, 8'h80, 8'h00, 1'b1, 8'h80, 8'hff, 8'h24);
    endtask
    task automatic t_shift_carry;
        op_chk(CSF_OP_RL, 8'h80, 8'h00, 1'b1, 8'h01, 8'he0, 8'h80);
        op_chk(CSF_OP_RR, 8'h01, 8'h00, 1'b1, 8'h80, 8'he0, 8'ha0);
        op_chk(CSF_OP_SRA, 8'h01, 8'h00, 1'b1, 8'h00, 8'he0, 8'hc0);
        op_chk(CSF_OP_RCF, 8'h00, 8'h00, 1'b0, 8'h00, 8'h80, 8'h00);
        op_chk(CSF_OP_SCF, 8'h00, 8'h00, 1'b0, 8'h00, 8'h80, 8'h80);
        op_chk(CSF_OP_CCF, 8'h00, 8'h00, 1'b0, 8'h00, 8'h80, 8'h00);
    endtask
    task automatic t_decimal;
        op_chk(CSF_OP_ADD, 8'h15, 8'h27, 1'b1, 8'h3c, 8'h0c, 8'h00);
        op_chk(CSF_OP_DECFIX, 8'h3c, 8'h00, 1'b1, 8'h42, 8'h00, 8'h00);
        op_chk(CSF_OP_SUB, 8'h42, 8'h15, 1'b1, 8'h2d, 8'h0c, 8'h0c);
        op_chk(CSF_OP_DECFIX, 8'h2d, 8'h00, 1'b1, 8'h27, 8'h00, 8'h00);
    endtask
    task automatic t_write_bank;
        wr(CSF_FLAGS_ADDR, 8'hff);
        op_chk(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 8'hff, 8'hfd);
        chk({7'h0, bank_sel}, 8'h01);
        wr(8'hd4, 8'h00);
        op_chk(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 8'hff, 8'hfd);
        op_chk(CSF_OP_SEL0, 8'h00, 8'h00, 1'b0, 8'h00, 8'h03, 8'h00);
        chk({7'h0, bank_sel}, 8'h00);
        op_chk(CSF_OP_SEL1, 8'h00, 8'h00, 1'b0, 8'h00, 8'h03, 8'h01);
    endtask
    task automatic t_cond;
        logic [15:0] v0, v1, v2;
        cond_scan(8'h00, v0);
        cond_scan(8'h0f, v1);
        cond_scan(8'h40, v2);
        chk(v0[7:0] ^ v1[7:0], 8'h00);
        chk(v0[15:8] ^ v1[15:8], 8'h00);
        chk({5'h0, v0[CSF_CC_ALWAYS], v0[CSF_CC_NEVER], v0[CSF_CC_EQ]}, 8'h04);
        chk({7'h0, v2[CSF_CC_EQ]}, 8'h01);
    endtask
    task automatic t_fast;
        want_fast = 1'b1;
        step;
        want_fast = 1'b0;
        step;
        chk({5'h0, fast_bit, irq_block, fast_ret}, 8'h07);
        op_chk(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 8'h02, 8'h02);
        want_ret = 1'b1;
        step;
        want_ret = 1'b0;
        step;
        chk({5'h0, fast_bit, irq_block, fast_ret}, 8'h00);
    endtask
    // ****************
    // run
    // ****************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // the whole run needs just over a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run;
        end
    end
    initial begin
        {rstn, op_valid, reg_wr, reg_rd, want_fast, want_ret} = 6'h00;
        op_code = CSF_OP_NONE;
        cond_code = CSF_CC_NEVER;
        {op_a, op_b, reg_addr, reg_wdata} = 32'h0;
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_arith;
        t_shift_carry;
        t_decimal;
        t_write_bank;
        t_cond;
        t_fast;
        complete_run;
    end
endmodule
